// [port_mac_ingress_rate_policer.sv]
// Port MAC control and ingress rate policer with AHB-Lite registers
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module port_mac_ingress_rate_policer #(
   parameter int REFILL_TICKS = port_policer_pkg::REFILL_CYCLES,
   parameter int NUM_PRIO = 8
) (
   // Clock, reset and register bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Frame attributes at the end of reception
   input wire logic frame_valid,
   input wire logic [13:0] frame_len,
   input wire logic [2:0] frame_prio,
   input wire logic frame_crc_err,
   input wire logic frame_oversize,
   input wire logic frame_undersize,
   input wire logic frame_bcast,
   input wire logic frame_mcast,
   input wire logic frame_flood,
   input wire logic frame_flow_ctrl,
   input wire logic filter_flow_ctrl,
   input wire logic congested,
   // Forwarding decision and flow control
   output logic fwd_valid,
   output logic fwd_normal,
   output logic fwd_mirror_only,
   output logic fwd_drop,
   output logic back_pressure,
   output logic pause_request
);
   // Register and meter state
   logic [7:0] mac_ctl1_q;
   logic [7:0] ing_ctl_q;
   logic [7:0] port_cfg_q;
   logic [6:0] code_pend_q [NUM_PRIO];
   logic [6:0] code_act_q [NUM_PRIO];
   logic [23:0] bucket_q [NUM_PRIO];
   logic wr_pend_q;
   logic [7:0] wr_idx_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;
   logic [31:0] tick_cnt_q;
   logic tick;
   logic exceeded_q;
   logic fwd_valid_q;
   logic fwd_normal_q;
   logic fwd_mirror_q;
   logic fwd_drop_q;
   logic back_pressure_q;
   logic pause_request_q;
   // Bus decode and frame metering
   logic addr_ok;
   logic addr_in_map;
   logic [7:0] addr_idx;
   logic frame_bad;
   logic in_class;
   logic charge;
   logic over_limit;
   logic [2:0] sel_bucket;
   logic [23:0] frame_cost;
   logic rate_fc;
   logic flow_en;

   // Class check for the selected frame class mode
   function automatic logic class_hit(input logic [1:0] mode, input logic b,
                                      input logic m, input logic f);
      logic hit;
      hit = 1'b0;
      unique case (port_policer_pkg::class_mode_e'(mode))
         port_policer_pkg::CLASS_ALL: hit = 1'b1;
         port_policer_pkg::CLASS_BMF: hit = b | m | f;
         port_policer_pkg::CLASS_BM: hit = b | m;
         port_policer_pkg::CLASS_B: hit = b;
      endcase
      return hit;
   endfunction

   // Credit granted per refill tick for a rate code
   function automatic logic [23:0] code_credit(input logic [6:0] code, input logic pkt);
      logic [23:0] step;
      step = pkt ? port_policer_pkg::PKT_CREDIT_STEP : port_policer_pkg::BYTE_CREDIT_STEP;
      return 24'({17'h0_0000, code} * step);
   endfunction

   // Bucket level plus credit, saturating at the full level
   function automatic logic [23:0] refill(input logic [23:0] level, input logic [23:0] add);
      logic [24:0] sum;
      sum = {1'b0, level} + {1'b0, add};
      if (sum > {1'b0, port_policer_pkg::BUCKET_MAX}) begin
         sum = {1'b0, port_policer_pkg::BUCKET_MAX};
      end
      return sum[23:0];
   endfunction

   // Word index falls on one of the priority rate code registers
   function automatic logic is_prio_idx(input logic [7:0] idx);
      return idx >= port_policer_pkg::PRIO_BASE_IDX && idx <= port_policer_pkg::PRIO_LAST_IDX;
   endfunction

   // Address decode on word index
   assign addr_idx = haddr[9:2];
   assign addr_ok = hsel & hready & htrans[1];
   assign addr_in_map = (haddr[31:10] == 22'h00_0000);

   // Bus address phase capture and read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end else if (ce) begin
         wr_pend_q <= addr_ok & hwrite & addr_in_map;
         wr_idx_q <= addr_idx;
         if (addr_ok & !hwrite) begin
            hrdata_q <= 32'h0000_0000;
            if (addr_in_map) begin
               if (addr_idx == port_policer_pkg::MAC_CTL1_IDX) begin
                  hrdata_q[7:0] <= mac_ctl1_q;
               end else if (addr_idx == port_policer_pkg::ING_CTL_IDX) begin
                  hrdata_q[7:0] <= ing_ctl_q;
               end else if (addr_idx == port_policer_pkg::PORT_CFG_IDX) begin
                  hrdata_q[7:0] <= port_cfg_q;
               end else if (addr_idx == port_policer_pkg::STATUS_IDX) begin
                  hrdata_q[2:0] <= {pause_request_q, back_pressure_q, exceeded_q};
               end else if (is_prio_idx(addr_idx)) begin
                  hrdata_q[6:0] <= code_pend_q[addr_idx[2:0]];
               end
            end
         end
      end
   end

   // Zero wait state, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else if (ce) begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   // Control register writes in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mac_ctl1_q <= port_policer_pkg::MAC_CTL1_RST;
         ing_ctl_q <= port_policer_pkg::ING_CTL_RST;
         port_cfg_q <= port_policer_pkg::PORT_CFG_RST;
      end else if (ce && wr_pend_q) begin
         if (wr_idx_q == port_policer_pkg::MAC_CTL1_IDX) begin
            mac_ctl1_q <= hwdata[7:0] & port_policer_pkg::MAC_CTL1_WMASK;
         end
         if (wr_idx_q == port_policer_pkg::ING_CTL_IDX) begin
            ing_ctl_q <= hwdata[7:0] & port_policer_pkg::ING_CTL_WMASK;
         end
         if (wr_idx_q == port_policer_pkg::PORT_CFG_IDX) begin
            port_cfg_q <= hwdata[7:0] & port_policer_pkg::PORT_CFG_WMASK;
         end
      end
   end

   // Rate codes held pending, all applied on the priority seven write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NUM_PRIO; i++) begin
            code_pend_q[i] <= port_policer_pkg::RATE_CODE_RST;
            code_act_q[i] <= port_policer_pkg::RATE_CODE_RST;
         end
      end else if (ce && wr_pend_q && is_prio_idx(wr_idx_q)) begin
         code_pend_q[wr_idx_q[2:0]] <= hwdata[6:0];
         if (wr_idx_q == port_policer_pkg::PRIO_LAST_IDX) begin
            for (int i = 0; i < NUM_PRIO - 1; i++) begin
               code_act_q[i] <= code_pend_q[i];
            end
            code_act_q[NUM_PRIO - 1] <= hwdata[6:0];
         end
      end
   end

   // Refill tick counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_q <= 32'h0000_0000;
      end else if (ce) begin
         tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      end
   end
   assign tick = (tick_cnt_q == 32'(REFILL_TICKS - 1));

   // Frame classification and bucket choice
   always_comb begin
      frame_bad = frame_crc_err | frame_oversize | frame_undersize;
      in_class = class_hit(ing_ctl_q[port_policer_pkg::ING_MODE_LSB +: 2],
                           frame_bcast, frame_mcast, frame_flood);
      sel_bucket = ing_ctl_q[port_policer_pkg::ING_PORT_BIT] ? 3'h0 : frame_prio;
   end

   // Metering cost, and whether the frame is charged or over its limit
   always_comb begin
      if (ing_ctl_q[port_policer_pkg::ING_PKT_MODE_BIT]) begin
         frame_cost = port_policer_pkg::PKT_COST;
      end else begin
         frame_cost = {10'h000, frame_len};
         if (ing_ctl_q[port_policer_pkg::ING_GAP_BIT]) begin
            frame_cost = frame_cost + port_policer_pkg::GAP_BYTES;
         end
         if (ing_ctl_q[port_policer_pkg::ING_PRE_BIT]) begin
            frame_cost = frame_cost + port_policer_pkg::PREAMBLE_BYTES;
         end
      end
      charge = frame_valid & !frame_bad & in_class & (code_act_q[sel_bucket] != 7'h00);
      over_limit = charge & (bucket_q[sel_bucket] < frame_cost);
   end

   // Token buckets, refilled on tick, charged by accepted frames
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NUM_PRIO; i++) begin
            bucket_q[i] <= port_policer_pkg::BUCKET_MAX;
         end
      end else if (ce) begin
         for (int i = 0; i < NUM_PRIO; i++) begin
            // A charge on a tick keeps the refill as well
            if (charge && !over_limit && sel_bucket == 3'(i)) begin
               if (tick) begin
                  bucket_q[i] <= refill(bucket_q[i] - frame_cost,
                     code_credit(code_act_q[i], ing_ctl_q[port_policer_pkg::ING_PKT_MODE_BIT]));
               end else begin
                  bucket_q[i] <= bucket_q[i] - frame_cost;
               end
            end else if (tick) begin
               bucket_q[i] <= refill(bucket_q[i],
                  code_credit(code_act_q[i], ing_ctl_q[port_policer_pkg::ING_PKT_MODE_BIT]));
            end
         end
      end
   end

   // Rate excess flag: a new excess wins over the tick clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         exceeded_q <= 1'b0;
      end else if (ce) begin
         if (over_limit) begin
            exceeded_q <= 1'b1;
         end else if (tick) begin
            exceeded_q <= 1'b0;
         end
      end
   end

   // Forwarding decision, one cycle after frame_valid
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fwd_valid_q <= 1'b0;
         fwd_normal_q <= 1'b0;
         fwd_mirror_q <= 1'b0;
         fwd_drop_q <= 1'b0;
      end else if (ce) begin
         fwd_valid_q <= frame_valid;
         fwd_normal_q <= 1'b0;
         fwd_mirror_q <= 1'b0;
         fwd_drop_q <= 1'b0;
         if (frame_valid) begin
            if (frame_flow_ctrl && filter_flow_ctrl) begin
               fwd_drop_q <= 1'b1;
            end else if (frame_bad) begin
               fwd_mirror_q <= mac_ctl1_q[port_policer_pkg::MAC_PASS_ALL_BIT];
               fwd_drop_q <= !mac_ctl1_q[port_policer_pkg::MAC_PASS_ALL_BIT];
            end else if (over_limit) begin
               fwd_drop_q <= 1'b1;
            end else begin
               fwd_normal_q <= 1'b1;
            end
         end
      end
   end

   // Flow control sources
   assign flow_en = port_cfg_q[port_policer_pkg::CFG_RX_FLOW_EN_BIT];
   assign rate_fc = exceeded_q & ing_ctl_q[port_policer_pkg::ING_FC_BIT] & flow_en;

   // Back pressure in half duplex, PAUSE in full duplex
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         back_pressure_q <= 1'b0;
         pause_request_q <= 1'b0;
      end else if (ce) begin
         back_pressure_q <= mac_ctl1_q[port_policer_pkg::MAC_BP_EN_BIT] &
            !port_cfg_q[port_policer_pkg::CFG_FULL_DUPLEX_BIT] & (congested | rate_fc);
         pause_request_q <= port_cfg_q[port_policer_pkg::CFG_FULL_DUPLEX_BIT] &
            port_cfg_q[port_policer_pkg::CFG_PAUSE_EN_BIT] & flow_en &
            (congested | rate_fc);
      end
   end

   // Outputs straight from flip-flops
   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign fwd_valid = fwd_valid_q;
   assign fwd_normal = fwd_normal_q;
   assign fwd_mirror_only = fwd_mirror_q;
   assign fwd_drop = fwd_drop_q;
   assign back_pressure = back_pressure_q;
   assign pause_request = pause_request_q;
endmodule

`default_nettype wire

// [port_policer_pkg.sv]
// Constants shared by the port MAC control and ingress policer
package port_policer_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] MAC_CTL1_IDX = 8'h01;
   localparam logic [7:0] ING_CTL_IDX = 8'h03;
   localparam logic [7:0] PRIO_BASE_IDX = 8'h10;
   localparam logic [7:0] PRIO_LAST_IDX = 8'h17;
   localparam logic [7:0] PORT_CFG_IDX = 8'h20;
   localparam logic [7:0] STATUS_IDX = 8'h21;
   // Port MAC control one fields
   localparam int MAC_PASS_ALL_BIT = 0;
   localparam int MAC_BP_EN_BIT = 3;
   localparam logic [7:0] MAC_CTL1_WMASK = 8'hbf;
   localparam logic [7:0] MAC_CTL1_RST = 8'h00;
   // Ingress limit control fields
   localparam int ING_PRE_BIT = 0;
   localparam int ING_GAP_BIT = 1;
   localparam int ING_MODE_LSB = 2;
   localparam int ING_FC_BIT = 4;
   localparam int ING_PKT_MODE_BIT = 5;
   localparam int ING_PORT_BIT = 6;
   localparam logic [7:0] ING_CTL_WMASK = 8'h7f;
   localparam logic [7:0] ING_CTL_RST = 8'h00;
   // Port configuration fields
   localparam int CFG_FULL_DUPLEX_BIT = 0;
   localparam int CFG_PAUSE_EN_BIT = 1;
   localparam int CFG_RX_FLOW_EN_BIT = 2;
   localparam logic [7:0] PORT_CFG_WMASK = 8'h07;
   localparam logic [7:0] PORT_CFG_RST = 8'h00;
   localparam logic [6:0] RATE_CODE_RST = 7'h00;
   // Frame classes
   typedef enum logic [1:0] {
      CLASS_ALL = 2'b00,
      CLASS_BMF = 2'b01,
      CLASS_BM = 2'b10,
      CLASS_B = 2'b11
   } class_mode_e;
   // Per-frame byte additions
   localparam logic [23:0] GAP_BYTES = 24'h00_000c;
   localparam logic [23:0] PREAMBLE_BYTES = 24'h00_0008;
   // Credit per refill tick: bytes per code step, and packets scaled by 100
   localparam logic [23:0] BYTE_CREDIT_STEP = 24'h00_007d;
   localparam logic [23:0] PKT_CREDIT_STEP = 24'h00_00c0;
   localparam logic [23:0] PKT_COST = 24'h00_0064;
   localparam logic [23:0] BUCKET_MAX = 24'h0f_ffff;
   // Refill period
   localparam int CLK_PERIOD_NS = 20;
   localparam int REFILL_PERIOD_NS = 1000000;
   localparam int REFILL_CYCLES = REFILL_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// [port_policer_assertions.sv]
// Checker for frame decisions and flow control outputs
`timescale 1ns/1ps
`default_nettype none
module port_policer_assertions (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic frame_valid,
   input wire logic frame_crc_err,
   input wire logic frame_oversize,
   input wire logic frame_undersize,
   input wire logic frame_flow_ctrl,
   input wire logic filter_flow_ctrl,
   input wire logic fwd_valid,
   input wire logic fwd_normal,
   input wire logic fwd_mirror_only,
   input wire logic fwd_drop,
   input wire logic back_pressure,
   input wire logic pause_request
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire bad_w = frame_crc_err | frame_oversize | frame_undersize;
   // Frame taken, then its kind
   sequence s_take;
      ce && frame_valid;
   endsequence
   sequence s_bad;
      s_take ##0 bad_w;
   endsequence
   property p_answer;
      s_take |=> fwd_valid;
   endproperty
   a_answer: assert property (p_answer) else $error("frame got no answer");
   property p_one;
      fwd_valid |-> $onehot({fwd_normal, fwd_mirror_only, fwd_drop});
   endproperty
   a_one: assert property (p_one) else $error("not one decision");
   property p_quiet;
      !fwd_valid |-> !(fwd_normal || fwd_mirror_only || fwd_drop);
   endproperty
   a_quiet: assert property (p_quiet) else $error("stray decision");
   property p_fc_drop;
      s_take ##0 (frame_flow_ctrl && filter_flow_ctrl) |=> fwd_drop;
   endproperty
   a_fc_drop: assert property (p_fc_drop) else $error("filtered frame kept");
   property p_bad;
      s_bad |=> !fwd_normal;
   endproperty
   a_bad: assert property (p_bad) else $error("bad frame forwarded");
   property p_mirror;
      fwd_mirror_only |-> $past(bad_w);
   endproperty
   a_mirror: assert property (p_mirror) else $error("good frame mirrored");
   property p_bp_rst;
      !$past(hresetn) |-> !back_pressure && !pause_request;
   endproperty
   a_bp_rst: assert property (p_bp_rst) else $error("flow control after reset");
   property p_duplex;
      pause_request |-> !back_pressure;
   endproperty
   a_duplex: assert property (p_duplex) else $error("both duplex modes");
endmodule
bind port_mac_ingress_rate_policer port_policer_assertions i_chk (.hclk, .hresetn, .ce,
   .frame_valid, .frame_crc_err, .frame_oversize, .frame_undersize, .frame_flow_ctrl,
   .filter_flow_ctrl, .fwd_valid, .fwd_normal, .fwd_mirror_only, .fwd_drop, .back_pressure,
   .pause_request);
`default_nettype wire

// [link_partner_model.sv]
// Link partner model that presents received frames to the port
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
   input wire logic hclk,
   output logic frame_valid,
   output logic [13:0] frame_len,
   output logic [2:0] frame_prio,
   output logic [6:0] frame_flags
);
   // Idle lines at time zero
   initial begin
      frame_valid = 1'b0;
      frame_len = 14'h0000;
      frame_prio = 3'h0;
      frame_flags = 7'h00;
   end
   // One frame end after g + 1 idle cycles; stale attributes scrambled after
   task automatic send(input int g, input logic [13:0] l, input logic [2:0] p,
      input logic [6:0] f);
      repeat (g + 1) @(posedge hclk);
      frame_valid <= 1'b1;
      frame_len <= l;
      frame_prio <= p;
      frame_flags <= f;
      @(posedge hclk);
      frame_valid <= 1'b0;
      frame_len <= ~l;
      frame_prio <= ~p;
      frame_flags <= ~f;
   endtask
endmodule
`default_nettype wire

// [port_mac_ingress_rate_policer_tb.sv]
// Self-checking bench for the port MAC control and ingress policer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
   $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module port_mac_ingress_rate_policer_tb;
   localparam logic [7:0] M1 = port_policer_pkg::MAC_CTL1_IDX, IG = port_policer_pkg::ING_CTL_IDX;
   localparam logic [7:0] CF = port_policer_pkg::PORT_CFG_IDX, ST = port_policer_pkg::STATUS_IDX;
   localparam logic [7:0] PB = port_policer_pkg::PRIO_BASE_IDX;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, filt = 1'b0, cong = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd, hrdata;
   logic [31:0] seed = 32'h794d_ccea;
   logic hreadyout, hresp, fv, fwd_valid, fwd_normal, fwd_mirror_only, fwd_drop, bp, pause;
   logic ebp, epa;
   logic [13:0] flen;
   logic [2:0] fprio;
   logic [6:0] ff;
   int error_cnt = 0, n_compared = 0, mac1 = 0, ing = 0, cfg = 0, exc = 0;
   int act[8] = '{default: 0}, pend[8] = '{default: 0}, bkt[8] = '{default: 1048575};
   int modes[9] = '{67, 3, 2, 1, 4, 8, 12, 32, 97};
   // Refill period beyond the run, so buckets only drain
   port_mac_ingress_rate_policer #(.REFILL_TICKS(90000)) i_dut (.hclk, .hresetn, .ce(1'b1),
      .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .frame_valid(fv), .frame_len(flen), .frame_prio(fprio),
      .frame_crc_err(ff[0]), .frame_oversize(ff[1]), .frame_undersize(ff[2]),
      .frame_bcast(ff[3]), .frame_mcast(ff[4]), .frame_flood(ff[5]), .frame_flow_ctrl(ff[6]),
      .filter_flow_ctrl(filt), .congested(cong), .fwd_valid, .fwd_normal, .fwd_mirror_only,
      .fwd_drop, .back_pressure(bp), .pause_request(pause));
   link_partner_model i_lp (.hclk, .frame_valid(fv), .frame_len(flen), .frame_prio(fprio),
      .frame_flags(ff));
   initial begin
      forever #10 hclk = ~hclk;
   end
   task automatic stop_test;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Bounded wait for a ready edge
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         stop_test();
      end
   endtask
   // One single word transfer
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {22'h00_0000, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
      bus(1'b0, idx, 32'h0000_0000);
      `CHK(rd, e)
   endtask
   // Write and mirror into the model
   task automatic wr(input logic [7:0] idx, input int v);
      bus(1'b1, idx, v);
      if (idx == M1) mac1 = v;
      if (idx == IG) ing = v;
      if (idx == CF) cfg = v;
      if (idx >= PB && idx < PB + 8) pend[idx - PB] = v;
      if (idx == PB + 8'h07) act = pend;
   endtask
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Decision model: 0 normal, 1 mirror, 2 drop; filtered frames still pay the meter
   function automatic int model(logic [6:0] f, int len, int p);
      int b, cost;
      bit hit, ov;
      b = ing[6] ? 0 : p;
      hit = f[2:0] == 0 && act[b] != 0 && (ing[3:2] == 0 || f[3] || (ing[3:2] < 3 && f[4])
         || (ing[3:2] == 1 && f[5]));
      cost = ing[5] ? 100 : len + (ing[1] ? 12 : 0);
      if (!ing[5] && ing[0]) cost += 8;
      ov = hit && bkt[b] < cost;
      if (ov) exc = 1;
      if (hit && !ov) bkt[b] -= cost;
      if (f[6] && filt) return 2;
      if (f[2:0] != 0) return mac1[0] ? 1 : 2;
      return ov ? 2 : 0;
   endfunction
   // Random frames, each decision against the model
   task automatic frames(input int n);
      logic [31:0] x;
      logic [6:0] f;
      int d;
      repeat (n) begin
         x = rnd();
         f = x[6:0];
         if (x[9:8] != 0) f[2:0] = 3'h0;
         if (x[11:10] != 0) f[6] = 1'b0;
         @(posedge hclk);
         filt <= x[12];
         i_lp.send(x[14:13], x[31:18], x[17:15], f);
         d = model(f, x[31:18], x[17:15]);
         #1;
         `CHK(fwd_valid, 1'b1)
         `CHK({fwd_drop, fwd_mirror_only, fwd_normal}, 3'b001 << d)
      end
   endtask
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values, masks and an unmapped place
      rchk(M1, 0);
      rchk(IG, 0);
      rchk(ST, 0);
      rchk(PB + 8'h07, 0);
      wr(M1, 255);
      rchk(M1, 32'h0000_00bf);
      wr(IG, 255);
      rchk(IG, 32'h0000_007f);
      wr(8'hff, 255);
      rchk(8'hff, 0);
      $display("test registers done");
      // Codes held pending until the last priority is written
      for (int i = 0; i < 7; i++) wr(8'(PB + i), (i == 2) ? 0 : i + 1);
      frames(40);
      wr(IG, 3);
      wr(M1, 0);
      frames(40);
      wr(PB + 8'h07, 8);
      rchk(PB + 8'h01, 2);
      $display("test pending codes done");
      foreach (modes[i]) begin
         wr(IG, modes[i]);
         wr(M1, i % 2);
         frames(200);
         $display("test mode %0d done", modes[i]);
      end
      // Back pressure and PAUSE against duplex and enables
      for (int k = 0; k < 64; k++) begin
         @(posedge hclk);
         cong <= k[4];
         wr(M1, k[0] << 3);
         wr(CF, k[3:1]);
         wr(IG, 16 * k[5]);
         repeat (2) @(posedge hclk);
         #1;
         ebp = k[0] && !k[1] && (k[4] || (exc && k[5] && k[3]));
         epa = k[1] && k[2] && k[3] && (k[4] || (exc && k[5] && k[3]));
         `CHK(bp, ebp)
         `CHK(pause, epa)
         rchk(ST, {29'h0000_0000, epa, ebp, exc[0]});
      end
      $display("test flow control done");
      // Mid-run reset returns registers and flags to their reset values
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rchk(M1, 0);
      rchk(ST, 0);
      $display("test reset done");
      stop_test();
   end
endmodule
`default_nettype wire
